// ===== rtl/swds_ingress_regs.sv
// Ingress configuration registers, priority table control and packet verdict.
`timescale 1ns/1ps

module swds_ingress_regs (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    // Register port
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    output logic [31:0] REG_RDATA_O,
    output logic REG_RDATA_VALID_O,
    // VLAN table command engine
    input wire logic VLAN_CMD_START_I,
    input wire logic VLAN_CMD_DONE_I,
    // Packet classification
    input wire swds_pkg::swds_pkt_t PKT_INFO_I,
    output swds_pkg::swds_verdict_t PKT_VERDICT_O,
    // Configuration to the datapath
    output logic VLAN_RULES_EN_O,
    output logic ECHO_ALLOW_O,
    output logic COUNTER_TEST_O,
    output logic [31:0] COUNTER_CLEAR_VALUE_O
);

    // ********************************************************
    // Reset release
    // ********************************************************
    logic rst_sync1;
    logic rst_n;

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_sync1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n <= rst_sync1;
        end
    end

    // ********************************************************
    // Address decode
    // ********************************************************
    wire sel_vlan_busy = REG_ADDR_I == swds_pkg::VLAN_COMMAND_BUSY_ADDR;
    wire sel_cmd = REG_ADDR_I == swds_pkg::PRIORITY_TABLE_COMMAND_ADDR;
    wire sel_wdat = REG_ADDR_I == swds_pkg::PRIORITY_TABLE_WRITE_DATA_ADDR;
    wire sel_rdat = REG_ADDR_I == swds_pkg::PRIORITY_TABLE_READ_DATA_ADDR;
    wire sel_tbusy = REG_ADDR_I == swds_pkg::PRIORITY_TABLE_BUSY_ADDR;
    wire sel_cfg = REG_ADDR_I == swds_pkg::GLOBAL_INGRESS_CONFIG_ADDR;

    // ********************************************************
    // Storage
    // ********************************************************
    logic vlan_busy;
    logic [7:0] cmd;
    logic [2:0] wdat;
    logic [2:0] rdat;
    logic [13:0] cfg;
    swds_pkg::swds_tbl_state_t tbl_state;
    swds_pkg::swds_tbl_state_t next_tbl_state;
    logic [1:0] wait_cnt;

    // A command that arrives while one is running is dropped; the host is
    // expected to poll busy first, so queueing was not worth the area.
    wire tbl_idle = tbl_state == swds_pkg::TBL_IDLE;
    wire cmd_launch = REG_WR_I && sel_cmd && tbl_idle; // R02
    wire tbl_busy = !tbl_idle; // R07
    wire cmd_is_read = cmd[swds_pkg::CMD_DIR_BIT]; // R03
    wire [5:0] cmd_index = cmd[swds_pkg::CMD_INDEX_MSB:0]; // R04
    wire do_access = tbl_state == swds_pkg::TBL_ACCESS;
    wire tbl_wr_en = do_access && !cmd_is_read; // R09
    wire tbl_rd_en = do_access && cmd_is_read; // R10
    wire wait_done = wait_cnt == swds_pkg::TBL_WAIT_CYCLES;

    // ********************************************************
    // VLAN busy flag
    // ********************************************************
    // Start wins over done so a back-to-back command is never lost.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            vlan_busy <= 1'b0;
        end else if (VLAN_CMD_START_I) begin
            vlan_busy <= 1'b1; // R01
        end else if (VLAN_CMD_DONE_I) begin
            vlan_busy <= 1'b0; // R01
        end
    end

    // ********************************************************
    // Writable registers
    // ********************************************************
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= swds_pkg::CMD_RESET;
        end else if (cmd_launch) begin
            cmd <= {REG_WDATA_I[7], 1'b0, REG_WDATA_I[5:0]}; // R02
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            wdat <= swds_pkg::PRI_RESET;
        end else if (REG_WR_I && sel_wdat) begin
            wdat <= REG_WDATA_I[swds_pkg::PRI_MSB:0]; // R06
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= swds_pkg::CFG_RESET; // R19
        end else if (REG_WR_I && sel_cfg) begin
            cfg <= REG_WDATA_I[13:0];
        end
    end

    // ********************************************************
    // Table command sequencer
    // ********************************************************
    always_comb begin
        next_tbl_state = tbl_state;
        unique case (tbl_state)
            swds_pkg::TBL_IDLE: begin
                if (cmd_launch) begin
                    next_tbl_state = swds_pkg::TBL_WAIT; // R02
                end
            end
            swds_pkg::TBL_WAIT: begin
                if (wait_done) begin
                    next_tbl_state = swds_pkg::TBL_ACCESS;
                end
            end
            swds_pkg::TBL_ACCESS: begin
                next_tbl_state = swds_pkg::TBL_IDLE; // R07
            end
            default: begin
                next_tbl_state = swds_pkg::TBL_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            tbl_state <= swds_pkg::TBL_IDLE;
        end else begin
            tbl_state <= next_tbl_state;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 2'h0;
        end else if (tbl_state == swds_pkg::TBL_WAIT) begin
            wait_cnt <= wait_cnt + 2'h1;
        end else begin
            wait_cnt <= 2'h0;
        end
    end

    // ********************************************************
    // Table memory
    // ********************************************************
    logic [2:0] tbl_cmd_pri;
    logic [2:0] tbl_pkt_pri;
    wire [5:0] pkt_dscp = PKT_INFO_I.tos[7:2]; // R22

    swds_pri_table #(
        .DEPTH(swds_pkg::TABLE_DEPTH),
        .AW(6),
        .DW(3)
    ) i_swds_pri_table (
        .clk_i(CLK_SYS_I),
        .wr_en_i(tbl_wr_en),
        .wr_addr_i(cmd_index),
        .wr_data_i(wdat),
        .rd_addr_a_i(cmd_index),
        .rd_data_a_o(tbl_cmd_pri),
        .rd_addr_b_i(pkt_dscp),
        .rd_data_b_o(tbl_pkt_pri)
    );

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            rdat <= swds_pkg::PRI_RESET;
        end else if (tbl_rd_en) begin
            rdat <= tbl_cmd_pri; // R10
        end
    end

    // ********************************************************
    // Register read
    // ********************************************************
    // Unmapped numbers read zero; reserved bits are forced to zero.
    wire [31:0] rd_mux =
        sel_vlan_busy ? {31'h0, vlan_busy} :
        sel_cmd ? {24'h0, cmd} :
        sel_wdat ? {29'h0, wdat} :
        sel_rdat ? {29'h0, rdat} : // R05
        sel_tbusy ? {31'h0, tbl_busy} : // R07
        sel_cfg ? {18'h0, cfg} : 32'h0;

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA_O <= 32'h0;
            REG_RDATA_VALID_O <= 1'b0;
        end else begin
            REG_RDATA_O <= REG_RD_I ? rd_mux : 32'h0;
            REG_RDATA_VALID_O <= REG_RD_I;
        end
    end

    // ********************************************************
    // Configuration fields
    // ********************************************************
    wire c_echo = cfg[swds_pkg::CFG_ECHO_BIT];
    wire [2:0] c_igmp_map =
        cfg[swds_pkg::CFG_IGMP_MAP_MSB:swds_pkg::CFG_IGMP_MAP_LSB];
    wire c_use_ip = cfg[swds_pkg::CFG_USE_IP_BIT];
    wire c_igmp_en = cfg[swds_pkg::CFG_IGMP_EN_BIT];
    wire c_cnt_test = cfg[swds_pkg::CFG_CNT_TEST_BIT];
    wire c_da_pri = cfg[swds_pkg::CFG_DA_PRI_BIT];
    wire c_filt_mc = cfg[swds_pkg::CFG_FILT_MC_BIT];
    wire c_drop_unk = cfg[swds_pkg::CFG_DROP_UNK_BIT];
    wire c_use_prec = cfg[swds_pkg::CFG_USE_PREC_BIT];
    wire c_vlan_pri = cfg[swds_pkg::CFG_VLAN_PRI_BIT];
    wire c_vlan_en = cfg[swds_pkg::CFG_VLAN_EN_BIT];

    assign VLAN_RULES_EN_O = c_vlan_en; // R20
    assign ECHO_ALLOW_O = c_echo; // R11
    assign COUNTER_TEST_O = c_cnt_test; // R15
    assign COUNTER_CLEAR_VALUE_O =
        c_cnt_test ? swds_pkg::CNT_TEST_VALUE : 32'h0; // R15

    // ********************************************************
    // Packet verdict
    // ********************************************************
    wire is_ip = PKT_INFO_I.is_ipv4 || PKT_INFO_I.is_ipv6;
    wire ip_ok = c_use_ip && is_ip; // R14
    wire vlan_ok = c_vlan_en && PKT_INFO_I.vlan_tagged; // R20
    wire da_ok = c_da_pri && PKT_INFO_I.da_found && PKT_INFO_I.da_static;
    wire [2:0] ip_pri = c_use_prec ? PKT_INFO_I.tos[7:5] : tbl_pkt_pri; // R19
    wire [2:0] pri_sel =
        da_ok ? PKT_INFO_I.da_pri : // R16
        (vlan_ok && (c_vlan_pri || !ip_ok)) ? PKT_INFO_I.vlan_pri : // R21
        ip_ok ? ip_pri : // R14
        PKT_INFO_I.port_pri;
    wire unk_uc = c_drop_unk && !PKT_INFO_I.da_multicast &&
        !PKT_INFO_I.da_found; // R18
    wire unk_mc = c_filt_mc && PKT_INFO_I.da_multicast &&
        !PKT_INFO_I.da_broadcast && !PKT_INFO_I.da_found; // R17
    wire igmp_hit = c_igmp_en && PKT_INFO_I.is_ipv4 &&
        PKT_INFO_I.is_igmp; // R13
    wire [2:0] src_mask = 3'h1 << PKT_INFO_I.src_port;
    wire [2:0] igmp_dest =
        c_echo ? c_igmp_map : (c_igmp_map & ~src_mask); // R11 R12

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            PKT_VERDICT_O <= '0;
        end else begin
            PKT_VERDICT_O.valid <= PKT_INFO_I.valid;
            PKT_VERDICT_O.pri <= pri_sel;
            PKT_VERDICT_O.drop <= PKT_INFO_I.valid && (unk_uc || unk_mc);
            PKT_VERDICT_O.to_monitor <= PKT_INFO_I.valid && igmp_hit;
            PKT_VERDICT_O.igmp_ports <= igmp_hit ? igmp_dest : 3'h0; // R12
        end
    end

endmodule // swds_ingress_regs

// ===== rtl/swds_pkg.sv
// Package with register map, field layouts and types for the ingress block.
// Function
// (R01) VLAN busy bit 0 is set while a VLAN table command runs, self-clears.
// (R02) Every host write to the table command register launches one access; writes made while the table is busy are dropped.
// (R03) Command bit 7 selects direction: one reads, zero writes the table.
// (R04) Command bits 5:0 select which of the 64 table entries is accessed.
// (R05) Host reads: command, poll busy until clear, then fetch read data.
// (R06) Host writes: load write data, issue command, wait for busy clear.
// (R07) Table busy bit 0 is set while a table access runs, self-clears.
// (R08) Table contents are not reset; host should write all entries first.
// (R09) A table write stores write-data bits 2:0 as the entry's priority.
// (R10) A table read places the entry's priority in read-data bits 2:0.
// (R11) Config bit 13 allows echo of monitored packets to their source port.
// (R12) Config bits 12:10 are the port bitmap receiving monitored IGMP packets.
// (R13) Config bit 7 enables IPv4 IGMP detection and forwarding to the bitmap.
// (R14) Config bit 9 lets the IP TOS or SC field choose the priority queue.
// (R15) Config bit 6 makes clear-on-read counters load 7FFF_FFCh when read.
// (R16) Config bit 5 with a static DA entry takes priority from that entry.
// (R17) Config bit 4 drops unknown multicast destinations, broadcasts exempt.
// (R18) Config bit 3 drops unicast packets whose destination is unknown.
// (R19) Config bit 2, reset one, picks TOS precedence over the table.
// (R20) Config bit 0 enables VLAN ingress rules and VLAN tag priority.
// (R21) Config bit 1 with VLANs enabled puts tag priority above IP priority.
// (R22) Table priority is looked up with the six-bit ToS/CS value.
package swds_pkg;

    // ********************************************************
    // Register numbers
    // ********************************************************
    localparam logic [15:0] VLAN_COMMAND_BUSY_ADDR = 16'h1810;
    localparam logic [15:0] PRIORITY_TABLE_COMMAND_ADDR = 16'h1811;
    localparam logic [15:0] PRIORITY_TABLE_WRITE_DATA_ADDR = 16'h1812;
    localparam logic [15:0] PRIORITY_TABLE_READ_DATA_ADDR = 16'h1813;
    localparam logic [15:0] PRIORITY_TABLE_BUSY_ADDR = 16'h1814;
    localparam logic [15:0] GLOBAL_INGRESS_CONFIG_ADDR = 16'h1840;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int BUSY_BIT = 0;
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_INDEX_MSB = 5;
    localparam int PRI_MSB = 2;
    localparam int CFG_ECHO_BIT = 13;
    localparam int CFG_IGMP_MAP_MSB = 12;
    localparam int CFG_IGMP_MAP_LSB = 10;
    localparam int CFG_USE_IP_BIT = 9;
    localparam int CFG_IGMP_EN_BIT = 7;
    localparam int CFG_CNT_TEST_BIT = 6;
    localparam int CFG_DA_PRI_BIT = 5;
    localparam int CFG_FILT_MC_BIT = 4;
    localparam int CFG_DROP_UNK_BIT = 3;
    localparam int CFG_USE_PREC_BIT = 2;
    localparam int CFG_VLAN_PRI_BIT = 1;
    localparam int CFG_VLAN_EN_BIT = 0;

    // ********************************************************
    // Reset values, masks and counts
    // ********************************************************
    localparam logic [13:0] CFG_RESET = 14'h0006;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [2:0] PRI_RESET = 3'h0;
    localparam logic [31:0] CNT_TEST_VALUE = 32'h07FFFFFC;
    localparam int TABLE_DEPTH = 64;
    localparam logic [1:0] TBL_WAIT_CYCLES = 2'h2;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        TBL_IDLE = 2'b00,
        TBL_WAIT = 2'b01,
        TBL_ACCESS = 2'b10
    } swds_tbl_state_t;

    typedef struct packed {
        logic valid;
        logic is_ipv4;
        logic is_ipv6;
        logic is_igmp;
        logic [7:0] tos;
        logic vlan_tagged;
        logic [2:0] vlan_pri;
        logic da_found;
        logic da_static;
        logic [2:0] da_pri;
        logic da_multicast;
        logic da_broadcast;
        logic [1:0] src_port;
        logic [2:0] port_pri;
    } swds_pkt_t;

    typedef struct packed {
        logic valid;
        logic [2:0] pri;
        logic drop;
        logic [2:0] igmp_ports;
        logic to_monitor;
    } swds_verdict_t;

endpackage

// ===== rtl/swds_pri_table.sv
// Priority table memory with one write port and two read ports.
`timescale 1ns/1ps

module swds_pri_table #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int DW = 3
) (
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    // Read ports
    input wire logic [AW-1:0] rd_addr_a_i,
    output logic [DW-1:0] rd_data_a_o,
    input wire logic [AW-1:0] rd_addr_b_i,
    output logic [DW-1:0] rd_data_b_o
);

    // No reset on the array: contents are undefined until software fills it.
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin // R08
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_a_o = mem[rd_addr_a_i];
    assign rd_data_b_o = mem[rd_addr_b_i];

endmodule // swds_pri_table

// ===== verification/swds_ingress_regs_properties.sv
// Concurrent checks on the ports of the ingress register block.
`timescale 1ns/1ps

module swds_ingress_regs_chk (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    // Register port
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic REG_RDATA_VALID_O,
    // VLAN table command engine
    input wire logic VLAN_CMD_START_I,
    input wire logic VLAN_CMD_DONE_I,
    // Packet classification
    input wire swds_pkg::swds_pkt_t PKT_INFO_I,
    input wire swds_pkg::swds_verdict_t PKT_VERDICT_O,
    // Configuration to the datapath
    input wire logic VLAN_RULES_EN_O,
    input wire logic ECHO_ALLOW_O,
    input wire logic COUNTER_TEST_O,
    input wire logic [31:0] COUNTER_CLEAR_VALUE_O
);
    // ********************************************************
    // Helpers
    // ********************************************************
    wire logic cfg_wr = REG_WR_I &&
        (REG_ADDR_I == swds_pkg::GLOBAL_INGRESS_CONFIG_ADDR);

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_B_I);

    // ********************************************************
    // Properties
    // ********************************************************
    chk_read_answer: assert property (REG_RD_I |=> REG_RDATA_VALID_O)
        else $error("read answer missing");
    chk_read_quiet: assert property (
        !REG_RDATA_VALID_O |-> REG_RDATA_O == 32'h0)
        else $error("read data not zero outside answer");
    chk_echo_load: assert property (
        cfg_wr |=> ECHO_ALLOW_O == $past(REG_WDATA_I[13]))
        else $error("echo enable not loaded");
    chk_echo_hold: assert property (
        !$stable(ECHO_ALLOW_O) |-> $past(cfg_wr))
        else $error("echo enable changed without write");
    chk_cnt_load: assert property (
        cfg_wr |=> COUNTER_TEST_O == $past(REG_WDATA_I[6]))
        else $error("counter test not loaded");
    chk_clear_value: assert property (
        COUNTER_CLEAR_VALUE_O ==
        (COUNTER_TEST_O ? swds_pkg::CNT_TEST_VALUE : 32'h0))
        else $error("counter clear value wrong");
    chk_vlan_load: assert property (
        cfg_wr |=> VLAN_RULES_EN_O == $past(REG_WDATA_I[0]))
        else $error("vlan enable not loaded");
    chk_verdict_valid: assert property (
        PKT_INFO_I.valid |=> PKT_VERDICT_O.valid)
        else $error("verdict missing");
    chk_verdict_idle: assert property (
        !PKT_INFO_I.valid |=> !PKT_VERDICT_O.drop &&
        !PKT_VERDICT_O.to_monitor)
        else $error("verdict action without packet");
    chk_igmp_echo: assert property (
        PKT_INFO_I.valid && !ECHO_ALLOW_O |=>
        (PKT_VERDICT_O.igmp_ports &
        (3'h1 << $past(PKT_INFO_I.src_port))) == 3'h0)
        else $error("monitored packet echoed to source port");
endmodule // swds_ingress_regs_chk

bind swds_ingress_regs swds_ingress_regs_chk i_swds_ingress_regs_chk (
    .CLK_SYS_I, .RST_B_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I,
    .REG_RDATA_O, .REG_RDATA_VALID_O, .VLAN_CMD_START_I, .VLAN_CMD_DONE_I,
    .PKT_INFO_I, .PKT_VERDICT_O, .VLAN_RULES_EN_O, .ECHO_ALLOW_O,
    .COUNTER_TEST_O, .COUNTER_CLEAR_VALUE_O);

// ===== verification/swds_ingress_regs_tb.sv
// Self-checking testbench for the ingress register block.
`timescale 1ns/1ps

module swds_ingress_regs_tb;
    // ********************************************************
    // Signals
    // ********************************************************
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [15:0] addr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rdata_valid;
    logic vlan_start = 1'b0;
    logic vlan_done = 1'b0;
    swds_pkg::swds_pkt_t pkt_info = '0;
    swds_pkg::swds_pkt_t pk;
    swds_pkg::swds_verdict_t verdict;
    logic vlan_en, echo, cnt_test;
    logic [31:0] clear_value;
    logic [5:0] idx;
    int error_cnt = 0;
    int check_count = 0;

    always #4 clk = ~clk;

    swds_ingress_regs i_swds_ingress_regs (
        .CLK_SYS_I(clk), .RST_B_I(rst_b), .REG_WR_I(wr_stb),
        .REG_RD_I(rd_stb), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata), .REG_RDATA_VALID_O(rdata_valid),
        .VLAN_CMD_START_I(vlan_start), .VLAN_CMD_DONE_I(vlan_done),
        .PKT_INFO_I(pkt_info), .PKT_VERDICT_O(verdict),
        .VLAN_RULES_EN_O(vlan_en), .ECHO_ALLOW_O(echo),
        .COUNTER_TEST_O(cnt_test), .COUNTER_CLEAR_VALUE_O(clear_value));

    // ********************************************************
    // Tasks
    // ********************************************************
    task close_out;
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Each access ends one idle cycle later, so strobes never toggle twice.
    task reg_wr(input logic [15:0] a, input logic [31:0] d);
        wr_stb = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 wr_stb = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task reg_chk(input logic [15:0] a, input logic [31:0] exp);
        rd_stb = 1'b1;
        addr = a;
        @(posedge clk);
        #1 rd_stb = 1'b0;
        chk({31'h0, rdata_valid}, 32'h1);
        chk(rdata, exp);
        @(posedge clk);
        #1;
    endtask

    task wait_idle;
        for (int n = 0; n < 20; n++) begin
            addr = swds_pkg::PRIORITY_TABLE_BUSY_ADDR;
            rd_stb = 1'b1;
            @(posedge clk);
            #1 rd_stb = 1'b0;
            if (rdata === 32'h0) begin
                @(posedge clk);
                #1;
                return;
            end
            @(posedge clk);
            #1;
        end
        error_cnt++;
        $display("ERROR %0t: table busy never cleared", $time);
        close_out();
    endtask

    task tbl(input logic [7:0] cmd);
        reg_wr(swds_pkg::PRIORITY_TABLE_COMMAND_ADDR, {24'h0, cmd});
        reg_chk(swds_pkg::PRIORITY_TABLE_BUSY_ADDR, 32'h1);
        wait_idle();
    endtask

    task pkt_chk(input logic [13:0] cfg, input swds_pkg::swds_pkt_t p,
                 input logic [2:0] pri, input logic drop,
                 input logic [3:0] mon);
        reg_wr(swds_pkg::GLOBAL_INGRESS_CONFIG_ADDR, {18'h0, cfg});
        p.valid = 1'b1;
        pkt_info = p;
        @(posedge clk);
        #1 pkt_info = '0;
        chk({26'h0, verdict.valid, verdict.pri, verdict.drop,
             verdict.to_monitor}, {26'h0, 1'b1, pri, drop, mon[3]});
        if (mon[3])
            chk({29'h0, verdict.igmp_ports}, {29'h0, mon[2:0]});
    endtask

    // ********************************************************
    // Sequence
    // ********************************************************
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        reg_chk(swds_pkg::GLOBAL_INGRESS_CONFIG_ADDR, 32'h6);
        reg_chk(swds_pkg::PRIORITY_TABLE_COMMAND_ADDR, 32'h0);
        reg_chk(swds_pkg::PRIORITY_TABLE_WRITE_DATA_ADDR, 32'h0);
        reg_chk(swds_pkg::PRIORITY_TABLE_BUSY_ADDR, 32'h0);
        reg_chk(swds_pkg::VLAN_COMMAND_BUSY_ADDR, 32'h0);
        reg_chk(16'h1815, 32'h0);
        // Reserved command bit 6 is set on purpose and must not stick.
        for (int i = 0; i < 4; i++) begin
            idx = 6'(i * 21);
            reg_wr(swds_pkg::PRIORITY_TABLE_WRITE_DATA_ADDR,
                   {29'h1FFFFFFF, idx[2:0] ^ 3'h6});
            reg_chk(swds_pkg::PRIORITY_TABLE_WRITE_DATA_ADDR,
                    {29'h0, idx[2:0] ^ 3'h6});
            tbl({2'b01, idx});
            reg_chk(swds_pkg::PRIORITY_TABLE_COMMAND_ADDR,
                    {26'h0, idx});
        end
        // A command issued while busy is dropped and leaves entry 42 alone.
        reg_wr(swds_pkg::PRIORITY_TABLE_COMMAND_ADDR, 32'h95);
        reg_wr(swds_pkg::PRIORITY_TABLE_COMMAND_ADDR, 32'h2A);
        wait_idle();
        reg_chk(swds_pkg::PRIORITY_TABLE_COMMAND_ADDR, 32'h95);
        reg_chk(swds_pkg::PRIORITY_TABLE_READ_DATA_ADDR, 32'h3);
        for (int i = 3; i >= 0; i--) begin
            idx = 6'(i * 21);
            tbl({2'b10, idx});
            reg_wr(swds_pkg::PRIORITY_TABLE_READ_DATA_ADDR, 32'hFFFFFFFF);
            reg_chk(swds_pkg::PRIORITY_TABLE_READ_DATA_ADDR,
                    {29'h0, idx[2:0] ^ 3'h6});
        end
        reg_wr(swds_pkg::PRIORITY_TABLE_BUSY_ADDR, 32'h1);
        reg_chk(swds_pkg::PRIORITY_TABLE_BUSY_ADDR, 32'h0);
        vlan_start = 1'b1;
        @(posedge clk);
        #1 vlan_start = 1'b0;
        reg_chk(swds_pkg::VLAN_COMMAND_BUSY_ADDR, 32'h1);
        vlan_done = 1'b1;
        @(posedge clk);
        #1 vlan_done = 1'b0;
        reg_chk(swds_pkg::VLAN_COMMAND_BUSY_ADDR, 32'h0);
        // A start and a done in one cycle must leave the flag set.
        vlan_start = 1'b1;
        vlan_done = 1'b1;
        @(posedge clk);
        #1 vlan_start = 1'b0;
        vlan_done = 1'b0;
        reg_chk(swds_pkg::VLAN_COMMAND_BUSY_ADDR, 32'h1);
        vlan_done = 1'b1;
        @(posedge clk);
        #1 vlan_done = 1'b0;
        reg_chk(swds_pkg::VLAN_COMMAND_BUSY_ADDR, 32'h0);
        reg_wr(swds_pkg::GLOBAL_INGRESS_CONFIG_ADDR, 32'hFFFFFFFF);
        reg_chk(swds_pkg::GLOBAL_INGRESS_CONFIG_ADDR, 32'h3FFF);
        chk({29'h0, echo, cnt_test, vlan_en}, 32'h7);
        chk(clear_value, 32'h07FFFFFC);
        reg_wr(swds_pkg::GLOBAL_INGRESS_CONFIG_ADDR, 32'h0);
        chk({29'h0, echo, cnt_test, vlan_en}, 32'h0);
        chk(clear_value, 32'h0);
        pk = '0;
        pk.is_ipv4 = 1'b1;
        pk.tos = 8'hA0;
        pk.port_pri = 3'h2;
        pkt_chk(14'h0204, pk, 3'h5, 1'b0, 4'h0);
        pkt_chk(14'h0004, pk, 3'h2, 1'b0, 4'h0);
        pk.tos = 8'h57;
        pkt_chk(14'h0200, pk, 3'h3, 1'b0, 4'h0);
        pk.is_ipv4 = 1'b0;
        pk.is_ipv6 = 1'b1;
        pk.port_pri = 3'h4;
        pkt_chk(14'h0204, pk, 3'h2, 1'b0, 4'h0);
        pk.vlan_tagged = 1'b1;
        pk.vlan_pri = 3'h7;
        pkt_chk(14'h0207, pk, 3'h7, 1'b0, 4'h0);
        pkt_chk(14'h0205, pk, 3'h2, 1'b0, 4'h0);
        pkt_chk(14'h0004, pk, 3'h4, 1'b0, 4'h0);
        pk.da_found = 1'b1;
        pk.da_static = 1'b1;
        pk.da_pri = 3'h1;
        pkt_chk(14'h0227, pk, 3'h1, 1'b0, 4'h0);
        pk = '0;
        pkt_chk(14'h0008, pk, 3'h0, 1'b1, 4'h0);
        pk.da_multicast = 1'b1;
        pkt_chk(14'h0008, pk, 3'h0, 1'b0, 4'h0);
        pkt_chk(14'h0010, pk, 3'h0, 1'b1, 4'h0);
        pk.da_broadcast = 1'b1;
        pkt_chk(14'h0010, pk, 3'h0, 1'b0, 4'h0);
        pk = '0;
        pk.da_found = 1'b1;
        pkt_chk(14'h0018, pk, 3'h0, 1'b0, 4'h0);
        pk = '0;
        pk.is_ipv4 = 1'b1;
        pk.is_igmp = 1'b1;
        pk.src_port = 2'h1;
        pkt_chk(14'h1C80, pk, 3'h0, 1'b0, 4'hD);
        pkt_chk(14'h3C80, pk, 3'h0, 1'b0, 4'hF);
        pkt_chk(14'h1C00, pk, 3'h0, 1'b0, 4'h0);
        // A second reset in mid-run must bring the registers back.
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        reg_chk(swds_pkg::GLOBAL_INGRESS_CONFIG_ADDR, 32'h6);
        reg_chk(swds_pkg::PRIORITY_TABLE_COMMAND_ADDR, 32'h0);
        reg_chk(swds_pkg::VLAN_COMMAND_BUSY_ADDR, 32'h0);
        close_out();
    end
endmodule // swds_ingress_regs_tb
